// >>> shared/vmg_pkg.sv
// Purpose: Constants for the virtual-mode gate entry and return sequencer.
// Assumes: AXI4-Lite register window of 8 address bits, 32-bit data.
// Notes: Flag positions follow the 32-bit flags register layout.
package vmg_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_FLAGS = 8'h04;
  localparam logic [7:0] A_SP = 8'h08;
  localparam logic [7:0] A_IP = 8'h0C;
  localparam logic [7:0] A_CS = 8'h10;
  localparam logic [7:0] A_SS = 8'h14;
  localparam logic [7:0] A_SEG_E = 8'h18;
  localparam logic [7:0] A_SEG_D = 8'h1C;
  localparam logic [7:0] A_SEG_F = 8'h20;
  localparam logic [7:0] A_SEG_G = 8'h24;
  localparam logic [7:0] A_GATE = 8'h28;
  localparam logic [7:0] A_GATE_IP = 8'h2C;
  localparam logic [7:0] A_L0_SP = 8'h30;
  localparam logic [7:0] A_L0_SS = 8'h34;
  localparam logic [7:0] A_STATUS = 8'h38;
  localparam logic [7:0] A_FAULT = 8'h3C;
  localparam logic [7:0] A_IRQ_STAT = 8'h40;
  localparam logic [7:0] A_IRQ_CLR = 8'h44;
  localparam logic [7:0] A_IRQ_EN = 8'h48;
  // Command bits.
  localparam int C_ENTRY = 0;
  localparam int C_RETURN = 1;
  localparam int C_OP32 = 2;
  // Flag bit positions.
  localparam int F_TF = 8;
  localparam int F_IF = 9;
  localparam int F_NT = 14;
  localparam int F_VM = 17;
  // Gate descriptor field positions and accepted types.
  localparam int G_TYPE_LSB = 16;
  localparam int G_DPL_LSB = 20;
  localparam int G_CONF = 22;
  localparam logic [3:0] T_TRAP32 = 4'hE;
  localparam logic [3:0] T_INT32 = 4'hF;
  // Interrupt event bits.
  localparam int I_ENTRY = 0;
  localparam int I_RETURN = 1;
  localparam int I_TASK = 2;
  localparam int I_GP = 3;
  // Privilege levels and reset values.
  localparam logic [1:0] PL_VM = 2'h3;
  localparam logic [1:0] PL_0 = 2'h0;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
  localparam logic [31:0] WORD = 32'h0000_0004;
  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_E_CHK = 4'h1,
    S_E_PUSH = 4'h2,
    S_R_CHK = 4'h3,
    S_R16 = 4'h4,
    S_R_FLG = 4'h5,
    S_R_POP = 4'h6,
    S_R_SEG = 4'h7,
    S_R_STK = 4'h8
  } vmg_state_type;
endpackage : vmg_pkg

// >>> logic/vmg_seq.sv
// Purpose: Sequencer for leaving virtual mode through a gate and returning.
// Assumes: System memory on CLK answers each MEM_REQ with a MEM_ACK pulse.
// Notes: Steps advance on the internal clock, one CLK in two.
// Function
// - Leaving virtual mode needs a 32-bit trap or interrupt gate to ring 0.
// - Legacy 16-bit return restores only low 16 flag bits, VM untouched.
// - Entry copies flags to a temporary, then clears VM, TF and IF.
// - Entry switches privilege from 3 to 0 and takes the level-0 stack.
// - Push G, F, D, E segments as 32-bit words, then null all four.
// - Then push old stack segment and old stack pointer, 32 bits each.
// - Then push the flags captured before clearing.
// - Push code segment and pointer, load gate target, run handler.
// - VM becomes 1 on return only for 32-bit return at privilege 0.
// - Nested-task flag set on return selects task return, no stack work.
// - Otherwise a 32-bit return loads flags first from stack image at pointer plus 8.
// - Pop pointer, then code segment word; load kind follows VM.
// - Add 4 to stack pointer to skip the flags image.
// - With VM 1, load E, D, F, G from pointer plus 8, 12, 16, 20.
// - With VM 0, null data selectors not valid for the resumed level.
// - If code REQUESTED_PRIVILEGE exceeds privilege, pop stack pointer then segment.
// - Resume in protected or virtual mode per the restored VM flag.
// - Conforming or nonzero-DESCRIPTOR_PRIVILEGE gate target raises fault, code = selector.
`timescale 1ns/1ps
module vmg_seq (
  input wire logic CLK,               // System clock, 10 MHz.
  input wire logic RST,               // Asynchronous reset, active high.
  input wire logic [7:0] S_AXI_AWADDR,  // Write address.
  input wire logic S_AXI_AWVALID,     // Write address valid.
  output logic S_AXI_AWREADY,         // Write address ready.
  input wire logic [31:0] S_AXI_WDATA,  // Write data.
  input wire logic [3:0] S_AXI_WSTRB,   // Write strobes.
  input wire logic S_AXI_WVALID,      // Write data valid.
  output logic S_AXI_WREADY,          // Write data ready.
  output logic [1:0] S_AXI_BRESP,     // Write response.
  output logic S_AXI_BVALID,          // Write response valid.
  input wire logic S_AXI_BREADY,      // Write response ready.
  input wire logic [7:0] S_AXI_ARADDR,  // Read address.
  input wire logic S_AXI_ARVALID,     // Read address valid.
  output logic S_AXI_ARREADY,         // Read address ready.
  output logic [31:0] S_AXI_RDATA,    // Read data.
  output logic [1:0] S_AXI_RRESP,     // Read response.
  output logic S_AXI_RVALID,          // Read data valid.
  input wire logic S_AXI_RREADY,      // Read data ready.
  output logic MEM_REQ,               // Stack memory request, level.
  output logic MEM_WE,                // Request is a write.
  output logic [31:0] MEM_ADDR,       // Stack byte address.
  output logic [31:0] MEM_WDATA,      // Data pushed.
  input wire logic [31:0] MEM_RDATA,  // Data popped, valid with MEM_ACK.
  input wire logic MEM_ACK,           // Memory completion pulse.
  output logic IRQ                    // Level interrupt.
);

  typedef struct packed {
    vmg_pkg::vmg_state_type st;
    logic [3:0] idx;
    logic tick;
    logic op32;
    logic kind86;
    logic [31:0] flags;
    logic [31:0] sp;
    logic [31:0] ip;
    logic [15:0] cs;
    logic [15:0] ss;
    logic [3:0][15:0] seg;
    logic [1:0] current_privilege;
    logic [31:0] gate;
    logic [31:0] gate_ip;
    logic [31:0] l0_sp;
    logic [15:0] l0_ss;
    logic [31:0] t_flags;
    logic [31:0] t_sp;
    logic [15:0] t_ss;
    logic [15:0] fault;
    logic [3:0] irq_st;
    logic [3:0] irq_en;
    logic irq;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic aw_ok;
    logic w_ok;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic mreq;
    logic mwe;
    logic [31:0] maddr;
    logic [31:0] mwdata;
  } vmg_regs_type;

  vmg_regs_type s_r;
  vmg_regs_type s_nxt;

  // Selector check: usable only when its REQUESTED_PRIVILEGE is not below the new level.
  function automatic logic [15:0] vmg_sel_fix(input logic [15:0] sel,
                                              input logic [1:0] lvl);
    vmg_sel_fix = (sel[1:0] < lvl) ? 16'h0000 : sel;
  endfunction : vmg_sel_fix

  // Byte-lane merge of a write into a 32-bit register image.
  function automatic logic [31:0] vmg_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    vmg_merge = m;
  endfunction : vmg_merge

  // Next-state logic for bus slave, sequencer and interrupt.
  always_comb begin
    logic [3:0] ev;
    logic [31:0] wv;
    logic [31:0] img;
    ev = 4'h0;
    wv = 32'h0000_0000;
    img = 32'h0000_0000;
    s_nxt = s_r;
    s_nxt.tick = ~s_r.tick;
    s_nxt.awready = S_AXI_AWVALID && !s_r.awready && !s_r.aw_ok
                    && !s_r.bvalid;
    s_nxt.wready = S_AXI_WVALID && !s_r.wready && !s_r.w_ok && !s_r.bvalid;
    s_nxt.arready = S_AXI_ARVALID && !s_r.arready && !s_r.rvalid;
    if (S_AXI_AWVALID && s_r.awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.waddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_r.wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.wdata = vmg_merge(32'h0000_0000, S_AXI_WDATA, S_AXI_WSTRB);
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end

    // Read decode; unmapped and write-only offsets read as zero.
    if (S_AXI_ARVALID && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      case (S_AXI_ARADDR)
        vmg_pkg::A_FLAGS: s_nxt.rdata = s_r.flags;
        vmg_pkg::A_SP: s_nxt.rdata = s_r.sp;
        vmg_pkg::A_IP: s_nxt.rdata = s_r.ip;
        vmg_pkg::A_CS: s_nxt.rdata = {16'h0000, s_r.cs};
        vmg_pkg::A_SS: s_nxt.rdata = {16'h0000, s_r.ss};
        vmg_pkg::A_SEG_E: s_nxt.rdata = {16'h0000, s_r.seg[0]};
        vmg_pkg::A_SEG_D: s_nxt.rdata = {16'h0000, s_r.seg[1]};
        vmg_pkg::A_SEG_F: s_nxt.rdata = {16'h0000, s_r.seg[2]};
        vmg_pkg::A_SEG_G: s_nxt.rdata = {16'h0000, s_r.seg[3]};
        vmg_pkg::A_GATE: s_nxt.rdata = s_r.gate;
        vmg_pkg::A_GATE_IP: s_nxt.rdata = s_r.gate_ip;
        vmg_pkg::A_L0_SP: s_nxt.rdata = s_r.l0_sp;
        vmg_pkg::A_L0_SS: s_nxt.rdata = {16'h0000, s_r.l0_ss};
        vmg_pkg::A_STATUS: begin
          s_nxt.rdata = {24'h00_0000, s_r.kind86, s_r.current_privilege, 1'b0, s_r.st};
        end
        vmg_pkg::A_FAULT: s_nxt.rdata = {16'h0000, s_r.fault};
        vmg_pkg::A_IRQ_STAT: s_nxt.rdata = {28'h000_0000, s_r.irq_st};
        vmg_pkg::A_IRQ_EN: s_nxt.rdata = {28'h000_0000, s_r.irq_en};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Write commit once address and data are both held; state registers
    // are frozen while the sequencer runs.
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      wv = s_r.wdata;
      if (s_r.waddr == vmg_pkg::A_IRQ_CLR) begin
        s_nxt.irq_st = s_r.irq_st & ~wv[3:0];
      end else if (s_r.waddr == vmg_pkg::A_IRQ_EN) begin
        s_nxt.irq_en = wv[3:0];
      end else if (s_r.st == vmg_pkg::S_IDLE) begin
        case (s_r.waddr)
          vmg_pkg::A_CMD: begin
            s_nxt.op32 = wv[vmg_pkg::C_OP32];
            if (wv[vmg_pkg::C_ENTRY]) begin
              s_nxt.st = vmg_pkg::S_E_CHK;
            end else if (wv[vmg_pkg::C_RETURN]) begin
              s_nxt.st = vmg_pkg::S_R_CHK;
            end
          end
          vmg_pkg::A_FLAGS: s_nxt.flags = wv;
          vmg_pkg::A_SP: s_nxt.sp = wv;
          vmg_pkg::A_IP: s_nxt.ip = wv;
          vmg_pkg::A_CS: s_nxt.cs = wv[15:0];
          vmg_pkg::A_SS: s_nxt.ss = wv[15:0];
          vmg_pkg::A_SEG_E: s_nxt.seg[0] = wv[15:0];
          vmg_pkg::A_SEG_D: s_nxt.seg[1] = wv[15:0];
          vmg_pkg::A_SEG_F: s_nxt.seg[2] = wv[15:0];
          vmg_pkg::A_SEG_G: s_nxt.seg[3] = wv[15:0];
          vmg_pkg::A_GATE: s_nxt.gate = wv;
          vmg_pkg::A_GATE_IP: s_nxt.gate_ip = wv;
          vmg_pkg::A_L0_SP: s_nxt.l0_sp = wv;
          vmg_pkg::A_L0_SS: s_nxt.l0_ss = wv[15:0];
          vmg_pkg::A_STATUS: s_nxt.current_privilege = wv[5:4];
          default: s_nxt.flags = s_r.flags;
        endcase
      end
    end

    // Memory completion drops the request; the state reacts below.
    if (s_r.mreq && MEM_ACK) begin
      s_nxt.mreq = 1'b0;
    end

    // Sequencer: new steps start only on the internal clock phase.
    case (s_r.st)
      vmg_pkg::S_IDLE: begin
        s_nxt.idx = 4'h0;
      end
      vmg_pkg::S_E_CHK: begin
        if (s_r.tick) begin
          if ((s_r.gate[vmg_pkg::G_TYPE_LSB +: 4] != vmg_pkg::T_TRAP32 &&
               s_r.gate[vmg_pkg::G_TYPE_LSB +: 4] != vmg_pkg::T_INT32) ||
              s_r.gate[vmg_pkg::G_CONF] ||
              s_r.gate[vmg_pkg::G_DPL_LSB +: 2] != vmg_pkg::PL_0) begin
            s_nxt.fault = s_r.gate[15:0];
            ev[vmg_pkg::I_GP] = 1'b1;
            s_nxt.st = vmg_pkg::S_IDLE;
          end else begin
            s_nxt.t_flags = s_r.flags;
            s_nxt.flags[vmg_pkg::F_VM] = 1'b0;
            s_nxt.flags[vmg_pkg::F_TF] = 1'b0;
            s_nxt.flags[vmg_pkg::F_IF] = 1'b0;
            s_nxt.current_privilege = vmg_pkg::PL_0;
            s_nxt.t_sp = s_r.sp;
            s_nxt.t_ss = s_r.ss;
            s_nxt.sp = s_r.l0_sp;
            s_nxt.ss = s_r.l0_ss;
            s_nxt.st = vmg_pkg::S_E_PUSH;
          end
        end
      end
      vmg_pkg::S_E_PUSH: begin
        if (!s_r.mreq && s_r.tick) begin
          case (s_r.idx)
            4'h0: img = {16'h0000, s_r.seg[3]};
            4'h1: img = {16'h0000, s_r.seg[2]};
            4'h2: img = {16'h0000, s_r.seg[1]};
            4'h3: img = {16'h0000, s_r.seg[0]};
            4'h4: img = {16'h0000, s_r.t_ss};
            4'h5: img = s_r.t_sp;
            4'h6: img = s_r.t_flags;
            4'h7: img = {16'h0000, s_r.cs};
            default: img = s_r.ip;
          endcase
          s_nxt.sp = s_r.sp - vmg_pkg::WORD;
          s_nxt.maddr = s_r.sp - vmg_pkg::WORD;
          s_nxt.mwdata = img;
          s_nxt.mwe = 1'b1;
          s_nxt.mreq = 1'b1;
        end else if (s_r.mreq && MEM_ACK) begin
          s_nxt.idx = s_r.idx + 4'h1;
          if (s_r.idx == 4'h3) begin
            s_nxt.seg = '0;
          end
          if (s_r.idx == 4'h8) begin
            s_nxt.cs = s_r.gate[15:0];
            s_nxt.ip = s_r.gate_ip;
            s_nxt.kind86 = 1'b0;
            ev[vmg_pkg::I_ENTRY] = 1'b1;
            s_nxt.st = vmg_pkg::S_IDLE;
          end
        end
      end
      vmg_pkg::S_R_CHK: begin
        if (s_r.tick) begin
          if (s_r.flags[vmg_pkg::F_NT]) begin
            ev[vmg_pkg::I_TASK] = 1'b1;
            s_nxt.st = vmg_pkg::S_IDLE;
          end else if (s_r.op32) begin
            s_nxt.st = vmg_pkg::S_R_FLG;
          end else begin
            s_nxt.st = vmg_pkg::S_R16;
          end
        end
      end
      vmg_pkg::S_R16, vmg_pkg::S_R_POP, vmg_pkg::S_R_STK: begin
        if (!s_r.mreq && s_r.tick) begin
          s_nxt.maddr = s_r.sp;
          s_nxt.mwe = 1'b0;
          s_nxt.mreq = 1'b1;
        end else if (s_r.mreq && MEM_ACK) begin
          s_nxt.sp = s_r.sp + vmg_pkg::WORD;
          s_nxt.idx = s_r.idx + 4'h1;
          if (s_r.idx == 4'h0) begin
            if (s_r.st == vmg_pkg::S_R_STK) begin
              s_nxt.t_sp = MEM_RDATA;
            end else begin
              s_nxt.ip = MEM_RDATA;
            end
          end else if (s_r.idx == 4'h1 && s_r.st == vmg_pkg::S_R_STK) begin
            s_nxt.ss = MEM_RDATA[15:0];
            s_nxt.sp = s_r.t_sp;
            s_nxt.kind86 = s_r.flags[vmg_pkg::F_VM];
            s_nxt.current_privilege = s_r.cs[1:0];
            ev[vmg_pkg::I_RETURN] = 1'b1;
            s_nxt.st = vmg_pkg::S_IDLE;
          end else if (s_r.idx == 4'h1) begin
            s_nxt.cs = MEM_RDATA[15:0];
            s_nxt.kind86 = s_r.flags[vmg_pkg::F_VM];
            if (s_r.st == vmg_pkg::S_R_POP) begin
              s_nxt.sp = s_r.sp + vmg_pkg::WORD + vmg_pkg::WORD;
              s_nxt.idx = 4'h0;
              s_nxt.st = vmg_pkg::S_R_SEG;
            end
          end else begin
            s_nxt.flags = {s_r.flags[31:16], MEM_RDATA[15:0]};
            ev[vmg_pkg::I_RETURN] = 1'b1;
            s_nxt.st = vmg_pkg::S_IDLE;
          end
        end
      end
      vmg_pkg::S_R_FLG: begin
        if (!s_r.mreq && s_r.tick) begin
          s_nxt.maddr = s_r.sp + vmg_pkg::WORD + vmg_pkg::WORD;
          s_nxt.mwe = 1'b0;
          s_nxt.mreq = 1'b1;
        end else if (s_r.mreq && MEM_ACK) begin
          s_nxt.flags = MEM_RDATA;
          if (s_r.current_privilege != vmg_pkg::PL_0) begin
            s_nxt.flags[vmg_pkg::F_VM] = s_r.flags[vmg_pkg::F_VM];
          end
          s_nxt.st = vmg_pkg::S_R_POP;
        end
      end
      vmg_pkg::S_R_SEG: begin
        if (!s_r.flags[vmg_pkg::F_VM]) begin
          if (s_r.tick) begin
            for (int i = 0; i < 4; i++) begin
              s_nxt.seg[i] = vmg_sel_fix(s_r.seg[i], s_r.cs[1:0]);
            end
            s_nxt.idx = 4'h0;
            s_nxt.st = vmg_pkg::S_R_STK;
          end
        end else if (!s_r.mreq && s_r.tick) begin
          s_nxt.maddr = s_r.sp + vmg_pkg::WORD + vmg_pkg::WORD
                        + {26'h000_0000, s_r.idx, 2'b00};
          s_nxt.mwe = 1'b0;
          s_nxt.mreq = 1'b1;
        end else if (s_r.mreq && MEM_ACK) begin
          s_nxt.seg[s_r.idx[1:0]] = MEM_RDATA[15:0];
          s_nxt.idx = s_r.idx + 4'h1;
          if (s_r.idx == 4'h3) begin
            s_nxt.idx = 4'h0;
            s_nxt.st = vmg_pkg::S_R_STK;
          end
        end
      end
      default: s_nxt.st = vmg_pkg::S_IDLE;
    endcase

    // outer pop only when REQUESTED_PRIVILEGE above level
    if (s_nxt.st == vmg_pkg::S_R_STK && s_r.st != vmg_pkg::S_R_STK &&
        s_r.cs[1:0] <= s_r.current_privilege) begin
      s_nxt.current_privilege = s_r.flags[vmg_pkg::F_VM] ? vmg_pkg::PL_VM : s_r.cs[1:0];
      ev[vmg_pkg::I_RETURN] = 1'b1;
      s_nxt.st = vmg_pkg::S_IDLE;
    end

    // Sticky events: a new event wins over a clear in the same cycle.
    s_nxt.irq_st = s_nxt.irq_st | ev;
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
  end

  // State register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
      s_r.flags <= vmg_pkg::RST_FLAGS;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register; both responses fixed at okay.
  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY = s_r.wready;
  assign S_AXI_BRESP = 2'h0;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = 2'h0;
  assign S_AXI_RVALID = s_r.rvalid;
  assign MEM_REQ = s_r.mreq;
  assign MEM_WE = s_r.mwe;
  assign MEM_ADDR = s_r.maddr;
  assign MEM_WDATA = s_r.mwdata;
  assign IRQ = s_r.irq;

endmodule : vmg_seq

// >>> verification/vmg_seq_checker.sv
// Purpose: Concurrent checks on the bus and stack ports of vmg_seq.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Push stepping is tracked only inside an unbroken run of pushes.
`timescale 1ns/1ps
module vmg_seq_checker (
  input wire logic CLK, // Clock.
  input wire logic RST, // Reset.
  input wire logic S_AXI_AWVALID, // Address valid.
  input wire logic S_AXI_AWREADY, // Address ready.
  input wire logic S_AXI_WVALID, // Data valid.
  input wire logic S_AXI_WREADY, // Data ready.
  input wire logic [1:0] S_AXI_BRESP, // Write response.
  input wire logic S_AXI_BVALID, // Response valid.
  input wire logic S_AXI_BREADY, // Response ready.
  input wire logic S_AXI_ARVALID, // Read address valid.
  input wire logic S_AXI_ARREADY, // Read address ready.
  input wire logic S_AXI_RVALID, // Read valid.
  input wire logic S_AXI_RREADY, // Read ready.
  input wire logic MEM_REQ, // Stack request.
  input wire logic MEM_WE, // Push.
  input wire logic [31:0] MEM_ADDR, // Stack address.
  input wire logic [31:0] MEM_WDATA, // Push data.
  input wire logic MEM_ACK // Completion.
);
  logic [31:0] push_addr_r;
  logic push_run_r;
  // Remembers the last acknowledged push; a write or a pop ends the run.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      push_addr_r <= 32'h0;
      push_run_r <= 1'b0;
    end else if (S_AXI_AWVALID || (MEM_REQ && !MEM_WE)) begin
      push_run_r <= 1'b0;
    end else if (MEM_REQ && MEM_ACK) begin
      push_addr_r <= MEM_ADDR;
      push_run_r <= 1'b1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_bvalid_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID) else $error("Write response dropped early");
  chk_rvalid_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID) else $error("Read data dropped early");
  chk_aw_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("Address ready longer than one cycle");
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("Read answer late");
  chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID && S_AXI_BRESP == 2'h0)
    else $error("Write answer late or not okay");
  chk_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ &&
    $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA))
    else $error("Stack request changed before acknowledge");
  chk_req_release: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("Stack request held after acknowledge");
  chk_push_step: assert property (
    $rose(MEM_REQ) && MEM_WE && push_run_r
    |-> MEM_ADDR == push_addr_r - 32'h4) else $error("Push step not four");
endmodule : vmg_seq_checker
bind vmg_seq vmg_seq_checker u_vmg_seq_checker (.CLK, .RST, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
  .S_AXI_RREADY, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK);

// >>> verification/vmg_mem_model.sv
// Purpose: Stack memory on the far side of the sequencer.
// Assumes: One access at a time, answered by a one-cycle ack pulse.
// Notes: Outside an answer the read data toggles so stale values show.
`timescale 1ns/1ps
module vmg_mem_model (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic req, // Request.
  input wire logic we, // Write.
  input wire logic [31:0] addr, // Byte address.
  input wire logic [31:0] wdata, // Write data.
  output logic [31:0] rdata, // Read data.
  output logic ack, // Answer pulse.
  input wire logic slow // Adds three wait cycles.
);
  logic [31:0] mem [0:255];
  logic [1:0] cnt_r;
  // Answers a pending access after the chosen wait, one word per address.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt_r <= 2'h0;
      rdata <= 32'h0;
    end else if (req && !ack && (!slow || cnt_r == 2'h3)) begin
      ack <= 1'b1;
      cnt_r <= 2'h0;
      if (we) mem[addr[9:2]] <= wdata;
      rdata <= we ? ~rdata : mem[addr[9:2]];
    end else begin
      ack <= 1'b0;
      cnt_r <= (req && !ack) ? cnt_r + 2'h1 : 2'h0;
      rdata <= ~rdata;
    end
  end
endmodule : vmg_mem_model

// >>> verification/tb_vmg_seq.sv
// Purpose: Self-checking bench for vmg_seq gate entry and return.
// Assumes: Registers over AXI4-Lite; stack in vmg_mem_model.
// Notes: Frames are inspected and preloaded in the model array.
`timescale 1ns/1ps
module tb_vmg_seq;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, MEM_REQ, MEM_WE, MEM_ACK, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic slow = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  // Flags, sp, ip, cs, ss, segments e/d/f/g, gate, gate ip, level-0 sp/ss.
  logic [31:0] ctx [13] = '{32'h0002_0302, 32'h1111_2220, 32'h0000_3456,
    32'h0000_1233, 32'h0000_5677, 32'h0000_E003, 32'h0000_D001,
    32'h0000_F003, 32'h0000_C003, 32'h000E_0008, 32'h0000_0400,
    32'h0000_0100, 32'h0000_0010};
  vmg_seq u_vmg_seq (.CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK, .IRQ);
  vmg_mem_model u_vmg_mem_model (.clk(CLK), .rst(RST), .req(MEM_REQ),
    .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA), .rdata(MEM_RDATA),
    .ack(MEM_ACK), .slow(slow));
  // Clock of 100 ns.
  initial forever #50 CLK = ~CLK;
  task automatic err(input string m);
    n_mismatch++;
    $display("FAIL %0t %s", $time, m);
  endtask : err
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    n_compared++;
    if (got !== exp) err(m);
  endtask : chk
  // Write cycle; address and data offered together, response taken late.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b1;
    @(posedge CLK);
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b1;
    @(posedge CLK);
    d = S_AXI_RDATA;
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] mk = 32'hFFFF_FFFF);
    logic [31:0] d;
    rd(a, d);
    chk(d & mk, e, $sformatf("register %h", a));
  endtask : rc
  task automatic wait_idle();
    logic [31:0] s;
    int n = 0;
    repeat (4) @(posedge CLK);
    do begin
      rd(vmg_pkg::A_STATUS, s);
      n++;
    end while (s[3:0] !== 4'h0 && n < 200);
    if (n >= 200) err("sequence hang");
  endtask : wait_idle
  task automatic t_reset();
    rc(vmg_pkg::A_FLAGS, vmg_pkg::RST_FLAGS);
    rc(vmg_pkg::A_STATUS, 32'h0);
    rc(8'h4C, 32'h0);
    chk(IRQ, 1'b0, "irq after reset");
  endtask : t_reset
  task automatic t_entry();
    int ord [9] = '{8, 7, 6, 5, 4, 1, 0, 3, 2};
    for (int i = 0; i < 13; i++) wr(vmg_pkg::A_FLAGS + 8'(4 * i), ctx[i]);
    wr(vmg_pkg::A_STATUS, 32'h0000_0030);
    wr(vmg_pkg::A_IRQ_EN, 32'h0);
    wr(vmg_pkg::A_CMD, 32'h1);
    wait_idle();
    for (int i = 0; i < 9; i++) begin
      chk(u_vmg_mem_model.mem[63 - i], ctx[ord[i]], "frame");
    end
    rc(vmg_pkg::A_FLAGS, 32'h0000_0002);
    rc(vmg_pkg::A_STATUS, 32'h0, 32'h0000_006F);
    rc(vmg_pkg::A_SP, 32'h0000_00DC);
    rc(vmg_pkg::A_SS, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      rc(vmg_pkg::A_SEG_E + 8'(4 * i), 32'h0);
    end
    rc(vmg_pkg::A_CS, 32'h0000_0008);
    rc(vmg_pkg::A_IP, 32'h0000_0400);
    chk(IRQ, 1'b0, "irq masked");
    rc(vmg_pkg::A_IRQ_STAT, 32'h1);
    wr(vmg_pkg::A_IRQ_EN, 32'hF);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b1, "irq enabled");
    wr(vmg_pkg::A_IRQ_CLR, 32'hF);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0, "irq cleared");
  endtask : t_entry
  // Full return into virtual mode with a slow stack memory.
  task automatic t_ret32();
    slow <= 1'b1;
    wr(vmg_pkg::A_CMD, 32'h6);
    wait_idle();
    slow <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rc(vmg_pkg::A_FLAGS + 8'(4 * i), ctx[i]);
    end
    rc(vmg_pkg::A_STATUS, 32'h0000_00E0, 32'h0000_00EF);
    rc(vmg_pkg::A_IRQ_STAT, 32'h2);
    wr(vmg_pkg::A_IRQ_CLR, 32'hF);
  endtask : t_ret32
  // Conforming, nonzero privilege and 16-bit gates are all refused.
  task automatic t_fault();
    logic [31:0] g [3] = '{32'h004E_0011, 32'h001E_0012, 32'h0006_0013};
    for (int i = 0; i < 3; i++) begin
      wr(vmg_pkg::A_GATE, g[i]);
      wr(vmg_pkg::A_CMD, 32'h1);
      wait_idle();
      rc(vmg_pkg::A_FAULT, {16'h0, g[i][15:0]});
      rc(vmg_pkg::A_IRQ_STAT, 32'h8);
      rc(vmg_pkg::A_SP, ctx[1]);
      wr(vmg_pkg::A_IRQ_CLR, 32'hF);
    end
  endtask : t_fault
  task automatic t_nested();
    wr(vmg_pkg::A_FLAGS, 32'h0000_4002);
    wr(vmg_pkg::A_CMD, 32'h6);
    wait_idle();
    rc(vmg_pkg::A_IRQ_STAT, 32'h4);
    rc(vmg_pkg::A_IP, ctx[2]);
    rc(vmg_pkg::A_SP, ctx[1]);
    wr(vmg_pkg::A_IRQ_CLR, 32'hF);
  endtask : t_nested
  // Legacy return keeps the upper flag half, virtual mode flag included.
  task automatic t_ret16();
    u_vmg_mem_model.mem[32] = 32'h0000_0777;
    u_vmg_mem_model.mem[33] = 32'h0000_2223;
    u_vmg_mem_model.mem[34] = 32'h0000_0AD5;
    wr(vmg_pkg::A_FLAGS, 32'h0002_0002);
    wr(vmg_pkg::A_SP, 32'h0000_0080);
    wr(vmg_pkg::A_CMD, 32'h2);
    wait_idle();
    rc(vmg_pkg::A_FLAGS, 32'h0002_0AD5);
    rc(vmg_pkg::A_IP, 32'h0000_0777);
    rc(vmg_pkg::A_IRQ_STAT, 32'h2);
    wr(vmg_pkg::A_FLAGS, 32'h2);
    wr(vmg_pkg::A_SP, 32'h80);
    wr(vmg_pkg::A_CMD, 32'h6);
    wait_idle();
    rc(vmg_pkg::A_SEG_D, 32'h0);
  endtask : t_ret16
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_entry();
    t_ret32();
    t_fault();
    t_nested();
    t_ret16();
    results();
  end
  // Watchdog against a hang.
  initial begin
    #3000000;
    err("timeout");
    results();
  end
endmodule : tb_vmg_seq
